// *** inc/spc_params.svh ***
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SPC_OFF_CONTROL_ONE  3'h0
`define SPC_OFF_CONTROL_TWO  3'h1
`define SPC_OFF_BAUD_SELECT  3'h2
`define SPC_OFF_STATUS_FLAGS 3'h3
`define SPC_OFF_RSVD_A       3'h4
`define SPC_OFF_SHIFT_DATA   3'h5
`define SPC_OFF_RSVD_B       3'h6
`define SPC_OFF_RSVD_C       3'h7

// ----------------------------------------------------------------------
// control_one fields
// ----------------------------------------------------------------------
`define SPC_C1_IRQ_ENABLE    7
`define SPC_C1_SYSTEM_ENABLE 6
`define SPC_C1_TX_EMPTY_IRQ  5
`define SPC_C1_MASTER_SELECT 4
`define SPC_C1_CLOCK_POL     3
`define SPC_C1_CLOCK_PHASE   2
`define SPC_C1_SEL_OUT_EN    1
`define SPC_C1_LOW_BIT_FIRST 0
`define SPC_C1_MODE_BITS     8'h0F

// ----------------------------------------------------------------------
// control_two, baud_select and status_flags fields
// ----------------------------------------------------------------------
`define SPC_C2_MODE_FAULT_EN 4
`define SPC_C2_WMASK         8'h1B
`define SPC_BR_WMASK         8'h77
`define SPC_BR_PRE_LSB       4
`define SPC_ST_DONE          7
`define SPC_ST_TX_EMPTY      5
`define SPC_ST_MODE_FAULT    4

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define SPC_RST_CONTROL_ONE  8'h04
`define SPC_RST_CONTROL_TWO  8'h00
`define SPC_RST_BAUD_SELECT  8'h00
`define SPC_ZERO_BYTE        8'h00
`define SPC_EDGES_PER_BYTE   5'h10

`endif

// *** inc/spc_pkg.sv ***
package spc_pkg;
   // Transfer engine states
   typedef enum logic {
      SPC_IDLE,
      SPC_RUN
   } spc_state_type;
endpackage : spc_pkg

// *** core/spc_core.sv ***
`include "spc_params.svh"

module spc_core (
   // Clock and reset
   input  wire logic                        mclk,
   input  wire logic                        reset_n,
   // Register port
   input  wire logic [2:0]                  regAddr,
   input  wire logic [7:0]                  regWdata,
   input  wire logic                        regWr,
   input  wire logic                        regRd,
   output logic      [7:0]                  regRdata,
   // Serial clock pin
   input  wire logic                        sckIn,
   output logic                             sckOut,
   output logic                             sckOe,
   // Data pins
   input  wire logic                        mosiIn,
   output logic                             mosiOut,
   output logic                             mosiOe,
   input  wire logic                        misoIn,
   output logic                             misoOut,
   output logic                             misoOe,
   // Select pin, active low
   input  wire logic                        selIn_n,
   output logic                             selOut_n,
   output logic                             selOe,
   // System side
   output logic                             irqReq,
   output logic                             pinsOwned
);
   import spc_pkg::*;

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic [7:0]    ctrlOne_r;        // control_one
   logic [7:0]    ctrlTwo_r;        // control_two
   logic [7:0]    baud_r;           // baud_select
   logic [7:0]    txBuf_r;          // Pending transmit byte
   logic          txFull_r;         // Transmit buffer holds data
   logic [7:0]    rxData_r;         // Last received byte
   logic          doneFlag_r;       // transfer_done_flag
   logic          faultFlag_r;      // mode_fault_flag
   logic          doneSeen_r;       // Status read saw done flag
   logic          faultSeen_r;      // Status read saw fault flag
   logic          cfgAbort_r;       // Abort pulse after a format write
   logic [7:0]    regRdata_r;       // Registered read data
   logic [2:0]    sckSync_r;        // Clock pin sync plus history
   logic [1:0]    mosiSync_r;       // Data-in pin sync
   logic [1:0]    misoSync_r;
   logic [2:0]    selSync_r;        // Select pin sync plus history
   spc_state_type state_r;          // Engine state
   logic [10:0]   divCnt_r;         // Half-period counter
   logic [4:0]    edgeCnt_r;        // Clock edges seen this byte
   logic [7:0]    txSh_r;           // Outgoing shifter
   logic [7:0]    rxSh_r;           // Incoming shifter
   logic          dataOut_r;        // Bit on the driven data pin
   logic          sckOut_r;
   logic          sckOe_r;
   logic          mosiOe_r;
   logic          misoOe_r;
   logic          selOut_n_r;
   logic          selOe_r;
   logic          irqReq_r;
   logic          pinsOwned_r;

   // Field views
   logic          system_enable, master, clock_polarity, clock_phase, select_output_enable, lsbFirst, mode_fault_enable;
   logic          txEmpty, selLow, selFell, inBit, edgeEv, sampleEv, driveEv;
   logic          modeFault, slaveDrop, abort, startXfer, xferDone, lastEdge;
   logic [4:0]    nextEdge;
   logic [10:0]   halfCnt;
   logic [7:0]    rxNext, rxFinal, statusByte;

   assign system_enable      = ctrlOne_r[`SPC_C1_SYSTEM_ENABLE];
   assign master   = ctrlOne_r[`SPC_C1_MASTER_SELECT];
   assign clock_polarity     = ctrlOne_r[`SPC_C1_CLOCK_POL];
   assign clock_phase     = ctrlOne_r[`SPC_C1_CLOCK_PHASE];
   assign select_output_enable     = ctrlOne_r[`SPC_C1_SEL_OUT_EN];
   assign lsbFirst = ctrlOne_r[`SPC_C1_LOW_BIT_FIRST];
   assign mode_fault_enable   = ctrlTwo_r[`SPC_C2_MODE_FAULT_EN];
   assign txEmpty  = ~txFull_r;

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   // Pins come from another domain; only stage two onward is used
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sckSync_r  <= 3'h0;
         mosiSync_r <= 2'h0;
         misoSync_r <= 2'h0;
         selSync_r  <= 3'h7;
      end else begin
         sckSync_r  <= {sckSync_r[1:0], sckIn};
         mosiSync_r <= {mosiSync_r[0], mosiIn};
         misoSync_r <= {misoSync_r[0], misoIn};
         selSync_r  <= {selSync_r[1:0], selIn_n};
      end
   end

   assign selLow  = ~selSync_r[1];
   assign selFell = selSync_r[2] & ~selSync_r[1];

   // ----------------------------------------------------------------------
   // Engine control terms
   // ----------------------------------------------------------------------
   // Divisor is (pre+1)*2^(rate+1); half of it per clock phase
   assign halfCnt  = ({8'h00, baud_r[`SPC_BR_PRE_LSB +: 3]} + 11'h001) << baud_r[2:0];
   assign nextEdge = edgeCnt_r + 5'h01;
   assign lastEdge = (nextEdge == `SPC_EDGES_PER_BYTE);
   // Master edges come from the divider, slave edges from the pin
   assign edgeEv   = (state_r == SPC_RUN) &&
                     (master ? (divCnt_r == 11'h000) : (sckSync_r[2] != sckSync_r[1]));
   // Phase 0 samples odd edges, phase 1 even edges
   assign sampleEv = edgeEv & (clock_phase ? ~nextEdge[0] : nextEdge[0]);
   assign driveEv  = edgeEv & (clock_phase ? nextEdge[0] : ~nextEdge[0]) & ~lastEdge;
   assign inBit    = master ? misoSync_r[1] : mosiSync_r[1];
   // Register keeps MSB in bit 7 whichever way the wire runs
   assign rxNext   = lsbFirst ? {inBit, rxSh_r[7:1]} : {rxSh_r[6:0], inBit};
   assign rxFinal  = sampleEv ? rxNext : rxSh_r;
   // Select low while a master watches it is a mode fault
   assign modeFault = system_enable & master & mode_fault_enable & ~select_output_enable & selLow;
   // Slave loses select mid byte: drop the byte
   assign slaveDrop = (state_r == SPC_RUN) & ~master & ~selLow;
   assign abort     = ~system_enable | modeFault | cfgAbort_r | slaveDrop;
   assign startXfer = system_enable & ~abort &
                      (master ? txFull_r : (selLow & (selFell | clock_phase)));
   assign xferDone  = edgeEv & lastEdge & ~abort;

   // ----------------------------------------------------------------------
   // Transfer engine
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_r   <= SPC_IDLE;
         divCnt_r  <= 11'h000;
         edgeCnt_r <= 5'h00;
         txSh_r    <= `SPC_ZERO_BYTE;
         rxSh_r    <= `SPC_ZERO_BYTE;
         dataOut_r <= 1'b0;
         sckOut_r  <= 1'b0;
      end else if (abort) begin
         // Forced idle; clock returns to its resting level
         state_r   <= SPC_IDLE;
         edgeCnt_r <= 5'h00;
         sckOut_r  <= clock_polarity;
      end else begin
         case (state_r)
            SPC_IDLE: begin
               sckOut_r  <= clock_polarity;
               edgeCnt_r <= 5'h00;
               if (startXfer) begin
                  state_r  <= SPC_RUN;
                  divCnt_r <= halfCnt - 11'h001;
                  rxSh_r   <= `SPC_ZERO_BYTE;
                  if (clock_phase) begin
                     // First bit goes out on edge one
                     txSh_r <= txBuf_r;
                  end else begin
                     // First bit must stand before edge one
                     dataOut_r <= lsbFirst ? txBuf_r[0] : txBuf_r[7];
                     txSh_r    <= lsbFirst ? {1'b0, txBuf_r[7:1]} : {txBuf_r[6:0], 1'b0};
                  end
               end
            end
            SPC_RUN: begin
               if (master) begin
                  // Divider paces the master clock
                  if (divCnt_r == 11'h000) begin
                     divCnt_r <= halfCnt - 11'h001;
                     sckOut_r <= ~sckOut_r;
                  end else begin
                     divCnt_r <= divCnt_r - 11'h001;
                  end
               end
               if (edgeEv) begin
                  edgeCnt_r <= nextEdge;
               end
               if (sampleEv) begin
                  rxSh_r <= rxNext;
               end
               if (driveEv) begin
                  dataOut_r <= lsbFirst ? txSh_r[0] : txSh_r[7];
                  txSh_r    <= lsbFirst ? {1'b0, txSh_r[7:1]} : {txSh_r[6:0], 1'b0};
               end
               if (edgeEv && lastEdge) begin
                  state_r <= SPC_IDLE;
               end
            end
            default: begin
               state_r <= SPC_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------------
   // Format changes in master mode, and any master-select change, raise a one-cycle abort
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctrlOne_r  <= `SPC_RST_CONTROL_ONE;
         ctrlTwo_r  <= `SPC_RST_CONTROL_TWO;
         baud_r     <= `SPC_RST_BAUD_SELECT;
         cfgAbort_r <= 1'b0;
      end else begin
         cfgAbort_r <= 1'b0;
         if (regWr && regAddr == `SPC_OFF_CONTROL_ONE) begin
            ctrlOne_r <= regWdata;
            if (regWdata[`SPC_C1_MASTER_SELECT] != master) begin
               cfgAbort_r <= 1'b1;
            end else if (master &&
                         ((regWdata ^ ctrlOne_r) & `SPC_C1_MODE_BITS) != `SPC_ZERO_BYTE) begin
               cfgAbort_r <= 1'b1;
            end
         end else if (regWr && regAddr == `SPC_OFF_CONTROL_TWO) begin
            ctrlTwo_r <= regWdata & `SPC_C2_WMASK;
            if (master && regWdata[`SPC_C2_MODE_FAULT_EN] != mode_fault_enable) begin
               cfgAbort_r <= 1'b1;
            end
         end else if (regWr && regAddr == `SPC_OFF_BAUD_SELECT) begin
            baud_r <= regWdata & `SPC_BR_WMASK;
            if (master && ((regWdata & `SPC_BR_WMASK) != baud_r)) begin
               cfgAbort_r <= 1'b1;
            end
         end
         // A mode fault drops the block back to slave
         if (modeFault) begin
            ctrlOne_r[`SPC_C1_MASTER_SELECT] <= 1'b0;
            // Hold idle one more cycle so a selected slave cannot start at once
            cfgAbort_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Data buffers
   // ----------------------------------------------------------------------
   // A data write while the buffer is full is dropped
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         txBuf_r  <= `SPC_ZERO_BYTE;
         txFull_r <= 1'b0;
         rxData_r <= `SPC_ZERO_BYTE;
      end else begin
         if (!system_enable) begin
            txFull_r <= 1'b0;
         end else if (startXfer && state_r == SPC_IDLE) begin
            txFull_r <= 1'b0;
         end else if (regWr && regAddr == `SPC_OFF_SHIFT_DATA && !txFull_r) begin
            txBuf_r  <= regWdata;
            txFull_r <= 1'b1;
         end
         if (xferDone) begin
            rxData_r <= rxFinal;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------------
   // Flag clears need a prior status read, except disable, which clears at once; a set in the same cycle wins over a read clear
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         doneFlag_r  <= 1'b0;
         faultFlag_r <= 1'b0;
         doneSeen_r  <= 1'b0;
         faultSeen_r <= 1'b0;
      end else if (!system_enable) begin
         doneFlag_r  <= 1'b0;
         faultFlag_r <= 1'b0;
         doneSeen_r  <= 1'b0;
         faultSeen_r <= 1'b0;
      end else begin
         if (regRd && regAddr == `SPC_OFF_STATUS_FLAGS) begin
            doneSeen_r  <= doneFlag_r;
            faultSeen_r <= faultFlag_r;
         end
         if (xferDone) begin
            doneFlag_r <= 1'b1;
         end else if (doneSeen_r && (regRd || regWr) && regAddr == `SPC_OFF_SHIFT_DATA) begin
            doneFlag_r <= 1'b0;
            doneSeen_r <= 1'b0;
         end
         if (modeFault) begin
            faultFlag_r <= 1'b1;
         end else if (faultSeen_r && regWr && regAddr == `SPC_OFF_CONTROL_ONE) begin
            faultFlag_r <= 1'b0;
            faultSeen_r <= 1'b0;
         end
      end
   end

   assign statusByte = {doneFlag_r, 1'b0, txEmpty, faultFlag_r, 4'h0};

   // ----------------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------------
   // Status and reserved offsets take no write at all
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         regRdata_r <= `SPC_ZERO_BYTE;
      end else if (!regRd) begin
         regRdata_r <= `SPC_ZERO_BYTE;
      end else if (regAddr == `SPC_OFF_CONTROL_ONE) begin
         regRdata_r <= ctrlOne_r;
      end else if (regAddr == `SPC_OFF_CONTROL_TWO) begin
         regRdata_r <= ctrlTwo_r;
      end else if (regAddr == `SPC_OFF_BAUD_SELECT) begin
         regRdata_r <= baud_r;
      end else if (regAddr == `SPC_OFF_STATUS_FLAGS) begin
         regRdata_r <= statusByte;
      end else if (regAddr == `SPC_OFF_SHIFT_DATA) begin
         regRdata_r <= rxData_r;
      end else begin
         regRdata_r <= `SPC_ZERO_BYTE;
      end
   end

   // ----------------------------------------------------------------------
   // Pin drivers and interrupt
   // ----------------------------------------------------------------------
   // Enables registered so every pin output leaves a flip-flop
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sckOe_r     <= 1'b0;
         mosiOe_r    <= 1'b0;
         misoOe_r    <= 1'b0;
         selOe_r     <= 1'b0;
         selOut_n_r  <= 1'b1;
         irqReq_r    <= 1'b0;
         pinsOwned_r <= 1'b0;
      end else begin
         pinsOwned_r <= system_enable;
         sckOe_r     <= system_enable & master;
         mosiOe_r    <= system_enable & master;
         misoOe_r    <= system_enable & ~master & selLow;
         selOe_r     <= system_enable & master & mode_fault_enable & select_output_enable;
         selOut_n_r  <= ~(state_r == SPC_RUN);
         irqReq_r    <= (ctrlOne_r[`SPC_C1_IRQ_ENABLE] & (doneFlag_r | faultFlag_r)) |
                        (ctrlOne_r[`SPC_C1_TX_EMPTY_IRQ] & system_enable & txEmpty);
      end
   end

   assign regRdata  = regRdata_r;
   assign sckOut    = sckOut_r;
   assign sckOe     = sckOe_r;
   assign mosiOut   = dataOut_r;
   assign mosiOe    = mosiOe_r;
   assign misoOut   = dataOut_r;
   assign misoOe    = misoOe_r;
   assign selOut_n  = selOut_n_r;
   assign selOe     = selOe_r;
   assign irqReq    = irqReq_r;
   assign pinsOwned = pinsOwned_r;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   sequence masterSelBusy;
      system_enable && master && mode_fault_enable && select_output_enable && state_r == SPC_RUN;
   endsequence

   sequence masterIdleHeld;
      (system_enable && master && state_r == SPC_IDLE && !abort) [*2];
   endsequence

   status_write_a: assert property (
      (regWr && regAddr == `SPC_OFF_STATUS_FLAGS && doneFlag_r && system_enable) |=> doneFlag_r)
      else $error("status write cleared done flag");

   reserved_read_a: assert property (
      (regRd && (regAddr == `SPC_OFF_RSVD_A || regAddr == `SPC_OFF_RSVD_B ||
                 regAddr == `SPC_OFF_RSVD_C)) |=> regRdata == `SPC_ZERO_BYTE)
      else $error("reserved offset read nonzero");

   disable_idle_a: assert property (
      !system_enable |=> (state_r == SPC_IDLE && !doneFlag_r && !faultFlag_r))
      else $error("disabled block not idle or flags set");

   irq_gate_a: assert property (
      (ctrlOne_r[`SPC_C1_IRQ_ENABLE] && doneFlag_r) |=> irqReq)
      else $error("done flag did not raise interrupt");

   tx_irq_mask_a: assert property (
      (!ctrlOne_r[`SPC_C1_TX_EMPTY_IRQ] && !doneFlag_r && !faultFlag_r) |=> !irqReq)
      else $error("masked transmit-empty raised interrupt");

   mode_switch_a: assert property (
      $changed(master) |=> state_r == SPC_IDLE)
      else $error("mode change left engine running");

   sel_output_a: assert property (
      masterSelBusy |=> (selOe && !selOut_n))
      else $error("select output not driven low");

   byte_edges_a: assert property (
      xferDone |-> (edgeCnt_r == 5'h0F && lastEdge) ##1 (state_r == SPC_IDLE && doneFlag_r))
      else $error("byte ended without sixteen edges");

   sck_idle_a: assert property (
      masterIdleHeld |=> sckOut == $past(clock_polarity))
      else $error("idle clock level wrong");

   cfg_abort_a: assert property (
      (regWr && regAddr == `SPC_OFF_CONTROL_ONE && master && system_enable &&
       regWdata[`SPC_C1_MASTER_SELECT] &&
       regWdata[`SPC_C1_CLOCK_PHASE] != clock_phase) |=> ##1 state_r == SPC_IDLE)
      else $error("phase change did not abort");

   pin_claim_a: assert property (
      $rose(system_enable) |=> pinsOwned)
      else $error("pins not claimed on enable");

endmodule : spc_core

// *** tb/spc_slave_model.sv ***
// ----------------------------------------
// Far-side slave device on the serial pins
// ----------------------------------------
module spc_slave_model (
   // Serial pins
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       sel_n,
   output logic            miso,
   // Format and payload
   input  wire logic       clock_phase,
   input  wire logic       lsbFirst,
   input  wire logic [7:0] txByte,
   output logic      [7:0] rxByte,
   output logic      [4:0] edgeCnt
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] txSh;  // Bits still to send

   // One bit out, in the agreed order
   task automatic sendBit();
      miso = lsbFirst ? txSh[0] : txSh[7];
      txSh = lsbFirst ? txSh >> 1 : txSh << 1;
   endtask : sendBit

   // Quiet start
   initial begin
      miso    = 1'b0;
      rxByte  = 8'h00;
      edgeCnt = 5'h00;
   end

   // Select is an input here; phase 0 shows the first bit at once
   always @(negedge sel_n) begin
      edgeCnt = 5'h00;
      txSh    = txByte;
      if (!clock_phase) sendBit();
   end

   // Released line shows the inverse, never a stale bit the master could trust
   always @(posedge sel_n) miso = ~miso;

   // Shift in step with the master clock: odd edges sample when phase is 0
   always @(sck) begin
      if (!sel_n) begin
         edgeCnt = edgeCnt + 5'h01;
         if (edgeCnt[0] ^ clock_phase) begin
            rxByte = lsbFirst ? {mosi, rxByte[7:1]} : {rxByte[6:0], mosi};
         end else begin
            sendBit();
         end
      end
   end
endmodule : spc_slave_model

// *** tb/spc_core_tb.sv ***
module spc_core_tb;
   timeunit 1ns;
   timeprecision 10ps;
   // ----------------------------------------
   // Pins, wire levels and bench state
   // ----------------------------------------
   logic       mclk, reset_n, regWr, regRd, extSel_n, clock_phase, lsbFirst, extSck, extMosi;
   logic       sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe;
   logic       selOut_n, selOe, irqReq, pinsOwned, modelMiso;
   logic [2:0] regAddr;
   logic [7:0] regWdata, regRdata, txByte, rxByte, rdVal, slvMosi, slvMiso;
   logic [4:0] edgeCnt;
   int         failures, n_compared;
   // Released lines fall to their pulled or idle level
   wire logic  sckW  = sckOe ? sckOut : extSck;
   wire logic  mosiW = mosiOe ? mosiOut : extMosi;
   wire logic  misoW = misoOe ? misoOut : modelMiso;
   wire logic  selW  = selOe ? selOut_n : extSel_n;

   spc_core dut_u (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sckIn(sckW), .sckOut(sckOut),
      .sckOe(sckOe), .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoW),
      .misoOut(misoOut), .misoOe(misoOe), .selIn_n(selW), .selOut_n(selOut_n),
      .selOe(selOe), .irqReq(irqReq), .pinsOwned(pinsOwned));
   spc_slave_model peer_u (.sck(sckW), .mosi(mosiW), .sel_n(selW), .miso(modelMiso),
      .clock_phase(clock_phase), .lsbFirst(lsbFirst), .txByte(txByte), .rxByte(rxByte), .edgeCnt(edgeCnt));

   // ----------------------------------------
   // Bus tasks and comparison
   // ----------------------------------------
   task automatic wcyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : wcyc
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge mclk);
      regWr    <= 1'b0;
   endtask : wr
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [2:0] a);
      @(posedge mclk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge mclk);
      regRd   <= 1'b0;
      #1;
      rdVal = regRdata;
   endtask : rd
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic rc(input logic [2:0] a, input logic [7:0] exp, input string what);
      rd(a);
      chk(what, exp, rdVal);
   endtask : rc
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run

   // Free-running system clock, 8 ns
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {reset_n, regWr, regRd, regAddr, regWdata, clock_phase, lsbFirst, txByte, extSck} = '0;
      extSel_n = 1'b1;
      extMosi  = 1'b1;
      slvMosi  = 8'h5A;
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      rc(3'h0, 8'h04, "control_one reset");
      rc(3'h3, 8'h20, "status reset");
      for (int a = 1; a < 8; a++) begin
         if (a != 5) wr(3'(a), 8'hFF);
      end
      rc(3'h1, 8'h1B, "control_two mask");
      rc(3'h2, 8'h77, "baud mask");
      rc(3'h3, 8'h20, "status kept");
      rc(3'h4, 8'h00, "reserved 4");
      rc(3'h6, 8'h00, "reserved 6");
      rc(3'h7, 8'h00, "reserved 7");
      $display("test registers done");
      // Fault detection on, half period of 8 cycles (link period 128 ns)
      wr(3'h1, 8'h10);
      wr(3'h2, 8'h03);
      // Every polarity, phase and bit order, select driven out
      for (int f = 0; f < 8; f++) begin
         clock_phase     <= f[1];
         lsbFirst <= f[0];
         txByte   <= 8'h3C ^ 8'(f);
         wr(3'h0, 8'hD2 | {4'h0, f[2], f[1], 1'b0, f[0]});
         wcyc(4);
         chk("sck idle", {7'h0, f[2]}, {7'h0, sckOut});
         chk("pins", 8'h0F, {4'h0, pinsOwned, selOe, mosiOe, sckOe});
         chk("irq idle", 8'h00, {7'h0, irqReq});
         wr(3'h5, 8'hA5 ^ 8'(f));
         rdVal = 8'h00;
         // Bounded wait for the done flag
         for (int n = 0; n < 200 && rdVal[7] !== 1'b1; n++) begin
            rd(3'h3);
         end
         if (rdVal[7] !== 1'b1) begin
            failures++;
            complete_run();
         end
         chk("irq done", 8'h01, {7'h0, irqReq});
         rc(3'h5, 8'h3C ^ 8'(f), "data in");
         chk("peer rx", 8'hA5 ^ 8'(f), rxByte);
         chk("edges", 8'h10, {3'h0, edgeCnt});
         wcyc(3);
         chk("irq cleared", 8'h00, {7'h0, irqReq});
      end
      $display("test formats done");
      // Format change mid-byte: no completion
      wr(3'h5, 8'h11);
      wcyc(30);
      wr(3'h0, 8'hDE);
      wcyc(200);
      rc(3'h3, 8'h20, "abort status");
      // Disable with the done flag standing
      wr(3'h5, 8'h22);
      wcyc(200);
      wr(3'h3, 8'h00);
      rc(3'h3, 8'hA0, "done standing");
      wr(3'h0, 8'h00);
      wcyc(3);
      chk("pins off", 8'h00, {4'h0, pinsOwned, selOe, mosiOe, sckOe});
      rc(3'h3, 8'h20, "flags cleared");
      $display("test abort done");
      // Select as fault input in master mode
      wr(3'h0, 8'hD0);
      wcyc(3);
      chk("sel released", 8'h00, {7'h0, selOe});
      @(posedge mclk) extSel_n <= 1'b0;
      wcyc(8);
      chk("irq fault", 8'h01, {7'h0, irqReq});
      rc(3'h3, 8'h30, "fault status");
      rc(3'h0, 8'hC0, "master dropped");
      wcyc(4);
      chk("slave pins", 8'h08, {4'h0, misoOe, mosiOe, sckOe, selOe});
      @(posedge mclk) extSel_n <= 1'b1;
      // Transmit-empty request and its mask
      wr(3'h0, 8'h60);
      wcyc(3);
      chk("irq tx empty", 8'h01, {7'h0, irqReq});
      wr(3'h0, 8'h40);
      wcyc(3);
      chk("irq masked", 8'h00, {7'h0, irqReq});
      $display("test select and irq done");
      // Bench as master: phase 0, MSB first, link period 125 ns
      wr(3'h5, 8'h96);
      @(posedge mclk) extSel_n <= 1'b0;
      // Keep link edges off the system clock edges
      #2.25;
      for (int i = 7; i >= 0; i--) begin
         extMosi = slvMosi[i];
         #62.5;
         slvMiso[i] = misoW;
         extSck = 1'b1;
         #62.5;
         extSck = 1'b0;
      end
      wcyc(4);
      extSel_n <= 1'b1;
      chk("slave miso", 8'h96, slvMiso);
      rc(3'h3, 8'hA0, "slave done");
      rc(3'h5, 8'h5A, "slave rx");
      $display("test slave link done");
      complete_run();
   end
endmodule : spc_core_tb
